// ==== pkg/lpcal_pkg.sv ====
// Constants and types for the low-power calibration control block
package lpcal_pkg;

    // Register bus widths
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;

    // Register offsets
    localparam logic [11:0] OFS_CAL_STATUS = 12'h06a;
    localparam logic [11:0] OFS_TRIG_CFG = 12'h06b;
    localparam logic [11:0] OFS_SOFT_TRIG = 12'h06c;
    localparam logic [11:0] OFS_LP_CTRL = 12'h06e;
    localparam logic [11:0] OFS_LP_STATUS = 12'h06f;
    localparam logic [11:0] OFS_VEC_EN = 12'h070;
    localparam logic [11:0] OFS_VEC_PORT = 12'h071;
    localparam logic [11:0] OFS_GAIN_TRIM_A = 12'h07a;

    // Field positions in lowpower_cal_control
    localparam int SLEEP_LSB = 5;
    localparam int SETTLE_LSB = 3;
    localparam int WAKE_TRIG_BIT = 1;
    localparam int LOWPOWER_CAL_ENABLE_BIT = 0;
    // Field position of the halted flag in the calibration status
    localparam int HALTED_BIT = 1;

    // Reset values
    localparam logic [7:0] RST_LP_CTRL = 8'h88;
    localparam logic [7:0] RST_TRIG_CFG = 8'h00;
    localparam logic [7:0] RST_SOFT_TRIG = 8'h01;
    localparam logic [7:0] RST_VEC_EN = 8'h00;

    // Interval base unit in clock periods
    localparam int INTERVAL_UNIT = 256;
    // Exponent tables for the sleep and settle codes
    localparam logic [5:0] SLEEP_EXP [8] = '{6'd3, 6'd15, 6'd18, 6'd21,
                                           6'd24, 6'd27, 6'd30, 6'd33};
    localparam logic [5:0] SETTLE_EXP [4] = '{6'd3, 6'd18, 6'd21, 6'd24};
    localparam int CNT_W = 42;

    // Calibration vector length in bytes
    localparam int VEC_LEN = 673;
    localparam int VEC_IDX_W = 10;

    // Register bus request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    // Scheduler states
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_CAL = 4'b0010,
        ST_SLEEP = 4'b0100,
        ST_SETTLE = 4'b1000
    } lp_state_t;

endpackage

// ==== verilog/lowpower_cal_ctrl.sv ====
// Low-power calibration scheduler and calibration-vector access
// Overview of operation
// - Sleep code bits 7:5 selects (2^n+1)*256 clocks, n from 3..33 table.
// - Sleep code used only with low-power enabled and trigger wake off.
// - Settle code bits 4:3 selects (2^n+1)*256 clocks before calibration.
// - Wake-on-trigger bit 1 picks timed sleep or sleep until trigger.
// - In trigger mode a sleeping core wakes when the trigger is low.
// - Low-power enable bit 0 acts only while background calibration runs.
// - Access enable bit 0 opens the vector data port for read and write.
// - Each port read returns the next vector byte; 673 bytes total.
// - Each port write loads the next vector byte; restore writes 673.
// - Gain trim A loads its factory value at reset; software may rewrite.
// - Halted flag reads 1 when calibration stopped, 0 when it resumes.
// - Trigger comes from pin when source bit is 1, else software bit.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ns
module lowpower_cal_ctrl
    import lpcal_pkg::*;
#(
    parameter int TICK_CYCLES = INTERVAL_UNIT
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Register port
    input wire reg_req_t bus_in,
    output logic [DATA_W-1:0] rdata_out,
    // Calibration engine side
    input wire logic background_cal_enable_in,
    input wire logic cal_halted_in,
    input wire logic cal_done_in,
    input wire logic [DATA_W-1:0] gain_trim_fuse_in,
    // Trigger pin
    input wire logic hw_cal_trigger_pin_in,
    // Core control
    output logic core_sleep_out,
    output logic cal_start_out,
    output logic [DATA_W-1:0] input_a_gain_trim_out
);

    // Longest interval is (2^33+1) ticks; a tick above 511 clocks would
    // overflow the CNT_W-bit counter, so such values are refused
    if (TICK_CYCLES < 1 || TICK_CYCLES > 511) begin : g_tick_range
        $error("TICK_CYCLES out of range");
    end

    // Interval length in clock cycles for an exponent
    // Shift and add stay inside CNT_W bits for every table entry
    function automatic logic [CNT_W-1:0] interval_cycles(
        input logic [5:0] n
    );
        logic [CNT_W-1:0] base;
        base = (CNT_W'(1) << n) + CNT_W'(1);
        return CNT_W'(base * CNT_W'(TICK_CYCLES));
    endfunction

    // Register state
    logic [7:0] lp_ctrl_q, lp_ctrl_d;
    logic [7:0] trig_cfg_q, trig_cfg_d;
    logic [7:0] soft_trig_q, soft_trig_d;
    logic [7:0] vec_en_q, vec_en_d;
    logic [7:0] gain_trim_q, gain_trim_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic [VEC_IDX_W-1:0] vec_idx_q, vec_idx_d;
    // Vector bytes have no reset; contents are undefined until restored
    logic [7:0] vec_mem [VEC_LEN];
    logic vec_wr;

    // Trigger pin synchroniser and filtered level
    logic trig_s1_q, trig_s2_q, trig_s3_q;
    logic trig_pin_q, trig_pin_d;

    // Scheduler state
    lp_state_t state_q, state_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic cal_start_q, cal_start_d;

    // Decoded control
    logic lp_active;
    logic trigger_level;
    logic sel_port, wr_hit, rd_hit;
    logic [2:0] sleep_interval_sel;
    logic [1:0] settle_interval_sel;
    logic wake_on_trigger;

    // Field views of the control register
    assign sleep_interval_sel = lp_ctrl_q[SLEEP_LSB +: 3];
    assign settle_interval_sel = lp_ctrl_q[SETTLE_LSB +: 2];
    assign wake_on_trigger = lp_ctrl_q[WAKE_TRIG_BIT];
    // Low-power mode gated by background calibration
    assign lp_active = lp_ctrl_q[LOWPOWER_CAL_ENABLE_BIT]
                       & background_cal_enable_in;
    // Trigger source select, unselected source ignored
    // The trigger is active low; its idle level is high
    assign trigger_level = trig_cfg_q[0] ? trig_pin_q
                                         : soft_trig_q[0];

    // Vector port decode
    // Halted flag is not enforced here; the host checks it first
    assign sel_port = (bus_in.addr == OFS_VEC_PORT) & vec_en_q[0];
    assign wr_hit = bus_in.wr & sel_port;
    assign rd_hit = bus_in.rd & sel_port;
    assign vec_wr = wr_hit;

    // Register writes, vector index and read data
    always_comb begin
        lp_ctrl_d = lp_ctrl_q;
        trig_cfg_d = trig_cfg_q;
        soft_trig_d = soft_trig_q;
        vec_en_d = vec_en_q;
        gain_trim_d = gain_trim_q;
        vec_idx_d = vec_idx_q;
        rdata_d = '0;
        if (bus_in.wr) begin
            unique case (bus_in.addr)
                OFS_LP_CTRL: lp_ctrl_d = bus_in.wdata;
                OFS_TRIG_CFG: trig_cfg_d = bus_in.wdata;
                OFS_SOFT_TRIG: soft_trig_d = bus_in.wdata;
                OFS_GAIN_TRIM_A: gain_trim_d = bus_in.wdata;
                OFS_VEC_EN: begin
                    // Reserved bits stay writable and read back
                    vec_en_d = bus_in.wdata;
                    // Rewind only on the rising edge of the enable
                    if (bus_in.wdata[0] && !vec_en_q[0]) begin
                        vec_idx_d = '0;
                    end
                end
                default: ;
            endcase
        end
        // Strobes never coincide, so the two decodes do not clash
        // Read data stand for one cycle only, zero otherwise
        if (bus_in.rd) begin
            unique case (bus_in.addr)
                OFS_CAL_STATUS:
                    rdata_d = 8'(cal_halted_in) << HALTED_BIT;
                OFS_TRIG_CFG: rdata_d = trig_cfg_q;
                OFS_SOFT_TRIG: rdata_d = soft_trig_q;
                OFS_LP_CTRL: rdata_d = lp_ctrl_q;
                OFS_LP_STATUS: rdata_d = {4'h0, state_q};
                OFS_VEC_EN: rdata_d = vec_en_q;
                OFS_GAIN_TRIM_A: rdata_d = gain_trim_q;
                OFS_VEC_PORT:
                    rdata_d = vec_en_q[0] ? vec_mem[vec_idx_q]
                                          : 8'h00;
                // Unmapped addresses read as zero
                default: rdata_d = '0;
            endcase
        end
        // Each port access steps to the next element, wrapping at the end
        // The wrap keeps a second full transfer aligned to the start
        if (wr_hit || rd_hit) begin
            if (vec_idx_q == VEC_IDX_W'(VEC_LEN - 1)) begin
                vec_idx_d = '0;
            end else begin
                vec_idx_d = vec_idx_q + VEC_IDX_W'(1);
            end
        end
    end

    // Register file flops; gain trim takes its factory value at reset
    // Other reset values are package constants or zero
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            lp_ctrl_q <= RST_LP_CTRL;
            trig_cfg_q <= RST_TRIG_CFG;
            soft_trig_q <= RST_SOFT_TRIG;
            vec_en_q <= RST_VEC_EN;
            gain_trim_q <= gain_trim_fuse_in;
            vec_idx_q <= '0;
            rdata_q <= '0;
        end else begin
            lp_ctrl_q <= lp_ctrl_d;
            trig_cfg_q <= trig_cfg_d;
            soft_trig_q <= soft_trig_d;
            vec_en_q <= vec_en_d;
            gain_trim_q <= gain_trim_d;
            vec_idx_q <= vec_idx_d;
            rdata_q <= rdata_d;
        end
    end

    // Calibration vector storage, one byte per port write
    // The write lands at the index before it steps
    always_ff @(posedge clk_in) begin
        if (vec_wr) begin
            vec_mem[vec_idx_q] <= bus_in.wdata;
        end
    end

    // Filtered pin level follows once the last two stages agree
    // The first stage is read by nothing but the second
    always_comb begin
        trig_pin_d = trig_pin_q;
        if (trig_s2_q == trig_s3_q) begin
            trig_pin_d = trig_s3_q;
        end
    end

    // Three-stage pin synchroniser
    // Stages reset high so that no false wake follows reset
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            trig_s1_q <= 1'b1;
            trig_s2_q <= 1'b1;
            trig_s3_q <= 1'b1;
            trig_pin_q <= 1'b1;
        end else begin
            trig_s1_q <= hw_cal_trigger_pin_in;
            trig_s2_q <= trig_s1_q;
            trig_s3_q <= trig_s2_q;
            trig_pin_q <= trig_pin_d;
        end
    end

    // Sleep and settle scheduler
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        cal_start_d = 1'b0;
        // Losing either enable parks the scheduler in idle at the next
        // edge, whatever it was doing
        if (!lp_active) begin
            state_d = ST_IDLE;
            cnt_d = '0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    // First pass starts as soon as low-power mode is on
                    state_d = ST_CAL;
                    cal_start_d = 1'b1;
                end
                ST_CAL: begin
                    // The engine reports the end of a pass
                    if (cal_done_in) begin
                        state_d = ST_SLEEP;
                        cnt_d = interval_cycles(
                            SLEEP_EXP[sleep_interval_sel]);
                    end
                end
                ST_SLEEP: begin
                    if (wake_on_trigger) begin
                        // Timed sleep ignored in trigger mode
                        if (!trigger_level) begin
                            state_d = ST_SETTLE;
                            cnt_d = interval_cycles(
                                SETTLE_EXP[settle_interval_sel]);
                        end
                    end else if (cnt_q <= CNT_W'(1)) begin
                        // Timed sleep counts down in autonomous mode only
                        state_d = ST_SETTLE;
                        cnt_d = interval_cycles(
                            SETTLE_EXP[settle_interval_sel]);
                    end else begin
                        cnt_d = cnt_q - CNT_W'(1);
                    end
                end
                ST_SETTLE: begin
                    // Settle time applies in both wake modes
                    if (cnt_q <= CNT_W'(1)) begin
                        state_d = ST_CAL;
                        cal_start_d = 1'b1;
                    end else begin
                        cnt_d = cnt_q - CNT_W'(1);
                    end
                end
                default: begin
                    // Illegal one-hot codes recover to idle
                    state_d = ST_IDLE;
                    cnt_d = '0;
                end
            endcase
        end
    end

    // Scheduler flops
    // A load of N into the counter gives exactly N cycles in the state
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_q <= ST_IDLE;
            cnt_q <= '0;
            cal_start_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            cal_start_q <= cal_start_d;
        end
    end

    // Outputs
    assign rdata_out = rdata_q;
    // Sleep level decodes the one-hot state flops
    assign core_sleep_out = (state_q == ST_SLEEP);
    // Start pulse comes straight from a flop, free of glitches
    assign cal_start_out = cal_start_q;
    assign input_a_gain_trim_out = gain_trim_q;

endmodule // lowpower_cal_ctrl

// ==== testbench/lowpower_cal_ctrl_sva.sv ====
// Checker for the low-power calibration control ports
`timescale 1ns/1ns
module lpcal_sva
    import lpcal_pkg::*;
#(parameter int TICK_CYCLES = INTERVAL_UNIT) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Register port
    input wire reg_req_t bus_in,
    input wire logic [DATA_W-1:0] rdata_out,
    // Engine, pin and core side
    input wire logic background_cal_enable_in,
    input wire logic cal_halted_in,
    input wire logic cal_done_in,
    input wire logic [DATA_W-1:0] gain_trim_fuse_in,
    input wire logic hw_cal_trigger_pin_in,
    input wire logic core_sleep_out,
    input wire logic cal_start_out,
    input wire logic [DATA_W-1:0] input_a_gain_trim_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);
    logic [7:0] lp_q;
    logic src_q, soft_q, en_q, t1;
    // Exact interval figures hold for a one-clock tick only
    assign t1 = (TICK_CYCLES == 1);
    // Shadow of the control registers, copied from bus writes
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            lp_q <= RST_LP_CTRL;
            {src_q, soft_q, en_q} <= 3'b010;
        end else if (bus_in.wr) begin
            if (bus_in.addr == OFS_LP_CTRL) lp_q <= bus_in.wdata;
            if (bus_in.addr == OFS_TRIG_CFG) src_q <= bus_in.wdata[0];
            if (bus_in.addr == OFS_SOFT_TRIG) soft_q <= bus_in.wdata[0];
            if (bus_in.addr == OFS_VEC_EN) en_q <= bus_in.wdata[0];
        end
    end
    // Register port and gain trim
    rd_idle_a: assert property (
        !$past(bus_in.rd) |-> rdata_out == 8'h00)
        else $error("rdata not idle");
    trim_load_a: assert property (
        $fell(rst_in) |-> input_a_gain_trim_out == $past(gain_trim_fuse_in))
        else $error("trim not loaded");
    trim_write_a: assert property (
        bus_in.wr && bus_in.addr == OFS_GAIN_TRIM_A
        |=> input_a_gain_trim_out == $past(bus_in.wdata)) else $error("trim");
    port_closed_a: assert property (
        bus_in.rd && bus_in.addr == OFS_VEC_PORT && !en_q
        |=> rdata_out == 8'h00) else $error("closed port read");
    // Scheduler timing
    start_pulse_a: assert property (
        cal_start_out |=> !cal_start_out) else $error("start too long");
    sleep_len_a: assert property (
        t1 && $rose(core_sleep_out) && lp_q[7:5] == 3'd0
        && lp_q[1:0] == 2'b01
        |-> core_sleep_out[*8] ##1 core_sleep_out ##1 !core_sleep_out)
        else $error("sleep length");
    settle_len_a: assert property (
        t1 && $fell(core_sleep_out) && background_cal_enable_in
        && lp_q[4:3] == 2'd0 && lp_q[0]
        |-> !cal_start_out[*8] ##1 !cal_start_out ##1 cal_start_out)
        else $error("settle length");
    soft_wake_a: assert property (
        core_sleep_out && lp_q[1] && !src_q && !soft_q
        |-> ##[1:4] !core_sleep_out) else $error("no wake");
    lp_off_a: assert property (
        !background_cal_enable_in |=> !core_sleep_out) else $error("asleep");
    // Main scenarios
    cover property ($rose(core_sleep_out));
    cover property (cal_start_out);
    cover property (bus_in.rd && bus_in.addr == OFS_VEC_PORT && en_q);
endmodule // lpcal_sva
bind lowpower_cal_ctrl lpcal_sva #(.TICK_CYCLES(TICK_CYCLES)) i_lpcal_sva (
    .clk_in, .rst_in, .bus_in, .rdata_out, .background_cal_enable_in,
    .cal_halted_in, .cal_done_in, .gain_trim_fuse_in,
    .hw_cal_trigger_pin_in, .core_sleep_out, .cal_start_out,
    .input_a_gain_trim_out);

// ==== testbench/lowpower_cal_ctrl_bench.sv ====
// Self-checking bench for the low-power calibration control block
`timescale 1ns/1ns
module lowpower_cal_ctrl_bench
    import lpcal_pkg::*;
;
    localparam int TICK = 1;
    localparam int SPAN0 = (2**3 + 1) * TICK; // Code 0 interval
    localparam int SPAN1 = (2**15 + 1) * TICK; // Sleep code 1 interval
    logic clk_in = 1'b0, rst_in = 1'b1, bg = 1'b0, done = 1'b0, pin = 1'b1;
    logic halted = 1'b0, sleep, start, seen = 1'b0;
    reg_req_t bus_in = '0;
    logic [7:0] fuse, rdata, trim, e, exp_q[$], vec[673];
    logic [31:0] seed = 32'd84036;
    int err_total = 0, n_tests = 0, n;
    lowpower_cal_ctrl #(.TICK_CYCLES(TICK)) i_lowpower_cal_ctrl (
        .clk_in, .rst_in, .bus_in, .rdata_out(rdata),
        .background_cal_enable_in(bg), .cal_halted_in(halted),
        .cal_done_in(done), .gain_trim_fuse_in(fuse),
        .hw_cal_trigger_pin_in(pin), .core_sleep_out(sleep),
        .cal_start_out(start), .input_a_gain_trim_out(trim));
    // Free-running clock
    always #4 clk_in = ~clk_in;
    // Xorshift source for data bytes
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task chk(input logic [15:0] got, input logic [15:0] want);
        n_tests++;
        if (got !== want) begin
            err_total++;
            $display("ERROR t=%0t got %h want %h", $time, got, want);
        end
    endtask
    // Checks each read answer against the oldest note
    always @(posedge clk_in) begin
        if (seen) chk(16'(rdata), 16'(exp_q.pop_front()));
        seen <= bus_in.rd;
    end
    // One bus cycle after an edge; a read notes its answer
    task acc(input logic w, input logic [11:0] a, input logic [7:0] d);
        bus_in <= '{a, w ? d : 8'h00, w, !w};
        if (!w) exp_q.push_back(d);
        @(posedge clk_in);
    endtask
    task idle(input int c);
        bus_in <= '0;
        repeat (c) @(posedge clk_in);
    endtask
    // Edges until sleep (s=1) or start (s=0) equals v
    task span(input bit s, input logic v);
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while ((s ? sleep : start) !== v && n < 40000);
    endtask
    // Ends a calibration pass and waits for sleep
    task to_sleep();
        done <= 1'b1;
        @(posedge clk_in);
        done <= 1'b0;
        span(1'b1, 1'b1);
    endtask
    task quiet();
        n = 0;
        repeat (20) begin
            @(posedge clk_in);
            if (start !== 1'b0 || sleep !== 1'b0) n++;
        end
        chk(16'(n), 16'd0);
    endtask
    task results();
        $display("tests %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Watchdog against a hang
    initial begin
        #(8 * 60000);
        err_total++;
        results();
    end
    // Main sequence
    initial begin
        fuse = rnd();
        repeat (3) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        acc(1'b0, OFS_LP_CTRL, {3'd4, 2'd1, 3'd0});
        acc(1'b0, OFS_TRIG_CFG, 8'h00);
        acc(1'b0, OFS_SOFT_TRIG, 8'h01);
        acc(1'b0, OFS_LP_STATUS, 8'h01);
        acc(1'b0, OFS_CAL_STATUS, 8'h00);
        acc(1'b0, OFS_VEC_EN, 8'h00);
        acc(1'b0, OFS_GAIN_TRIM_A, fuse);
        acc(1'b0, OFS_VEC_PORT, 8'h00);
        acc(1'b0, 12'h0ff, 8'h00);
        e = rnd();
        acc(1'b1, OFS_GAIN_TRIM_A, e);
        acc(1'b0, OFS_GAIN_TRIM_A, e);
        idle(2);
        chk(16'(trim), 16'(e));
        $display("test registers done");
        halted <= 1'b1;
        acc(1'b0, OFS_CAL_STATUS, 8'h01 << HALTED_BIT);
        acc(1'b1, OFS_VEC_EN, 8'h01);
        for (int i = 0; i < 673; i++) begin
            vec[i] = rnd();
            acc(1'b1, OFS_VEC_PORT, vec[i]);
        end
        acc(1'b0, OFS_VEC_PORT, vec[0]);
        acc(1'b0, OFS_VEC_PORT, vec[1]);
        acc(1'b1, OFS_VEC_EN, 8'h00);
        acc(1'b1, OFS_VEC_PORT, 8'h5a);
        acc(1'b0, OFS_VEC_PORT, 8'h00);
        acc(1'b1, OFS_VEC_EN, 8'h01);
        for (int i = 0; i < 673; i++) begin
            acc(1'b0, OFS_VEC_PORT, vec[i]);
        end
        halted <= 1'b0;
        acc(1'b0, OFS_CAL_STATUS, 8'h00);
        idle(2);
        $display("test vector done");
        bg <= 1'b1;
        acc(1'b1, OFS_LP_CTRL, 8'h01);
        idle(1);
        span(1'b0, 1'b1);
        chk(16'(start), 16'd1);
        to_sleep();
        span(1'b1, 1'b0);
        chk(16'(n), 16'(SPAN0));
        span(1'b0, 1'b1);
        chk(16'(n), 16'(SPAN0));
        acc(1'b1, OFS_LP_CTRL, {3'd1, 2'd0, 3'd1});
        idle(1);
        to_sleep();
        span(1'b1, 1'b0);
        chk(16'(n), 16'(SPAN1));
        span(1'b0, 1'b1);
        chk(16'(n), 16'(SPAN0));
        $display("test timed done");
        acc(1'b1, OFS_LP_CTRL, 8'h03);
        idle(1);
        to_sleep();
        repeat (30) @(posedge clk_in);
        chk(16'(sleep), 16'd1);
        acc(1'b0, OFS_LP_STATUS, 8'h04);
        acc(1'b1, OFS_SOFT_TRIG, 8'h00);
        idle(1);
        span(1'b1, 1'b0);
        chk(16'(n < 6), 16'd1);
        span(1'b0, 1'b1);
        chk(16'(n), 16'(SPAN0));
        acc(1'b1, OFS_TRIG_CFG, 8'h01);
        idle(1);
        to_sleep();
        repeat (30) @(posedge clk_in);
        chk(16'(sleep), 16'd1);
        pin <= 1'b0;
        span(1'b1, 1'b0);
        chk(16'(n < 8), 16'd1);
        pin <= 1'b1;
        $display("test trigger done");
        span(1'b0, 1'b1);
        to_sleep();
        bg <= 1'b0;
        @(posedge clk_in);
        quiet();
        acc(1'b1, OFS_LP_CTRL, 8'h02);
        bg <= 1'b1;
        idle(1);
        quiet();
        $display("test disable done");
        results();
    end
endmodule // lowpower_cal_ctrl_bench
